/* File: design/tsr_defs.vh */
/*
  Constants of the temperature sensor register block: pointer codes, configuration
  fields, reset values, bus address and conversion timing.
  Assumes inclusion by tsr_i2c_slave.v and tsr_top.v only.
*/
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH

// ----------------------------------------------------------------
// register select pointer codes
// ----------------------------------------------------------------
`define TSR_PTR_TEMP 3'h0
`define TSR_PTR_CFG 3'h1
`define TSR_PTR_HYST 3'h2
`define TSR_PTR_OTEMP 3'h3
`define TSR_PTR_TRIG 3'h4

// ----------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------
`define TSR_CFG_SHUTDOWN 0
`define TSR_CFG_INT_MODE 1
`define TSR_CFG_POLARITY 2
`define TSR_CFG_FQ_LO 3
`define TSR_CFG_FQ_HI 4
`define TSR_CFG_ONESHOT 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TSR_RST_PTR 8'h00
`define TSR_RST_TEMP 16'h0000
`define TSR_RST_CFG 8'h00
`define TSR_RST_HYST 16'h4b00
`define TSR_RST_OTEMP 16'h5000

// ----------------------------------------------------------------
// serial bus address and timing
// ----------------------------------------------------------------
`define TSR_BUS_ADDR_HI 4'h9
`define TSR_CLK_MHZ 200
`define TSR_CONV_PERIOD_MS 60
`define TSR_CONV_CYCLES (`TSR_CONV_PERIOD_MS * 1000 * `TSR_CLK_MHZ)

`endif

/* File: design/tsr_i2c_slave.v */
/*
  Two-wire serial slave engine: finds start and stop, matches the 7-bit address,
  acknowledges, hands received bytes to the register block and shifts read bytes out.
  Assumes scl and sda are raw pins; both are sampled by two flip-flops on clk.
*/
`timescale 1ns/100ps
`include "tsr_defs.vh"

module tsr_i2c_slave (
  input wire clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  input wire [2:0] addr_sel,
  input wire [7:0] rd_byte,
  output reg sda_oe_q,
  output reg start_q,
  output reg stop_q,
  output reg wr_stb_q,
  output reg wr_first_q,
  output reg [7:0] wr_byte_q,
  output reg rd_stb_q
);

  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RD = 3'h5;
  localparam S_RACK = 3'h6;

  reg scl_s1_q, scl_s2_q, scl_p_q;
  reg sda_s1_q, sda_s2_q, sda_p_q;
  reg [2:0] adr_s1_q, adr_s2_q;
  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg done_q;
  reg rw_q;
  reg first_q;
  reg acked_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;

  wire scl_rise = scl_s2_q & ~scl_p_q;
  wire scl_fall = ~scl_s2_q & scl_p_q;
  wire start_c = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  wire stop_c = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
      adr_s1_q <= 3'h0;
      adr_s2_q <= 3'h0;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
      adr_s1_q <= addr_sel;
      adr_s2_q <= adr_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_first_q <= 1'b0;
      wr_byte_q <= 8'h00;
      rd_stb_q <= 1'b0;
    end else begin
      start_q <= start_c;
      stop_q <= stop_c;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (start_c) begin
        state_q <= S_ADDR;
        cnt_q <= 3'h0;
        done_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR, S_WR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              cnt_q <= cnt_q + 3'h1;
              done_q <= (cnt_q == 3'h7);
            end else if (scl_fall && done_q) begin
              done_q <= 1'b0;
              if (state_q == S_ADDR) begin
                if (shift_q[7:1] == {`TSR_BUS_ADDR_HI, adr_s2_q}) begin
                  rw_q <= shift_q[0];
                  first_q <= 1'b1;
                  sda_oe_q <= 1'b1;
                  state_q <= S_AACK;
                end else begin
                  state_q <= S_IDLE;
                end
              end else begin
                // the first byte of a write goes to the pointer
                wr_stb_q <= 1'b1;
                wr_first_q <= first_q;
                wr_byte_q <= shift_q;
                first_q <= 1'b0;
                sda_oe_q <= 1'b1;
                state_q <= S_WACK;
              end
            end
          end
          S_AACK, S_WACK: begin
            if (scl_fall) begin
              cnt_q <= 3'h0;
              if (state_q == S_AACK && rw_q) begin
                tx_q <= rd_byte;
                rd_stb_q <= 1'b1;
                sda_oe_q <= ~rd_byte[7];
                state_q <= S_RD;
              end else begin
                sda_oe_q <= 1'b0;
                state_q <= S_WR;
              end
            end
          end
          S_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 3'h1;
              done_q <= (cnt_q == 3'h7);
            end else if (scl_fall) begin
              if (done_q) begin
                done_q <= 1'b0;
                sda_oe_q <= 1'b0;
                acked_q <= 1'b0;
                state_q <= S_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_q <= ~tx_q[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              acked_q <= ~sda_s2_q;
              if (sda_s2_q) begin
                state_q <= S_IDLE;
              end
            end else if (scl_fall && acked_q) begin
              cnt_q <= 3'h0;
              tx_q <= rd_byte;
              rd_stb_q <= 1'b1;
              sda_oe_q <= ~rd_byte[7];
              state_q <= S_RD;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // tsr_i2c_slave

/* File: design/tsr_top.v */
/*
  Register set and control of a digital temperature sensor behind a two-wire bus:
  pointer, temperature, limits, configuration, one-shot, fault queue and alert pin.
  Assumes an external converter on CLK_SYS that answers CONV_START with CONV_DONE.
*/
`timescale 1ns/100ps
`include "tsr_defs.vh"

module tsr_top #(
  parameter [31:0] CONV_CYCLES = `TSR_CONV_CYCLES
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire [2:0] ADDR_SEL,
  output reg ALERT_OUT,
  output reg ALERT_OE,
  output reg CONV_START,
  input wire CONV_DONE,
  input wire [11:0] CONV_CODE,
  output reg SENSOR_PWR_EN
);

  function [2:0] faults_needed;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: faults_needed = 3'h1;
        2'h1: faults_needed = 3'h2;
        2'h2: faults_needed = 3'h4;
        default: faults_needed = 3'h6;
      endcase
    end
  endfunction

  // pick the byte of a 16-bit register that the read index points at
  function [7:0] pick_byte;
    input [15:0] val;
    input idx;
    begin
      if (idx) begin
        pick_byte = val[7:0];
      end else begin
        pick_byte = val[15:8];
      end
    end
  endfunction

  // signed compare shared by the fault and the hysteresis tests
  function at_or_above;
    input [15:0] a;
    input [15:0] b;
    begin
      at_or_above = $signed(a) >= $signed(b);
    end
  endfunction

  wire sda_oe_c;
  wire start_p, stop_p, wr_stb, wr_first, rd_stb;
  wire [7:0] wr_byte;
  reg [7:0] rd_byte;

  reg [7:0] ptr_q;
  reg [15:0] temp_q;
  reg [7:0] cfg_q;
  reg [15:0] hyst_q;
  reg [15:0] otemp_q;
  reg [7:0] msb_hold_q;
  reg wr_idx_q;
  reg rd_idx_q;
  reg [31:0] period_q;
  reg busy_q;
  reg trig_pend_q;
  reg [2:0] fault_cnt_q;
  reg alert_q;
  reg below_q;
  reg read_seen_q;

  wire shutdown = cfg_q[`TSR_CFG_SHUTDOWN];
  wire oneshot = cfg_q[`TSR_CFG_ONESHOT];
  wire int_mode = cfg_q[`TSR_CFG_INT_MODE];
  wire polarity = cfg_q[`TSR_CFG_POLARITY];
  wire [2:0] needed = faults_needed(cfg_q[`TSR_CFG_FQ_HI:`TSR_CFG_FQ_LO]);
  wire normal_run = ~shutdown & ~oneshot;
  wire [15:0] new_temp = {CONV_CODE, 4'h0};
  wire is_fault = at_or_above(new_temp, otemp_q);
  wire is_below = ~at_or_above(new_temp, hyst_q);
  reg [2:0] fault_next;
  wire data_wr = wr_stb & ~wr_first;
  wire trig_wr = (wr_stb & wr_first & (wr_byte[2:0] == `TSR_PTR_TRIG))
               | (data_wr & (ptr_q[2:0] == `TSR_PTR_TRIG));

  // ----------------------------------------------------------------
  // fault counter next value
  // ----------------------------------------------------------------
  always @* begin
    if (!is_fault) begin
      fault_next = 3'h0;
    // saturates at six so a long fault run never wraps to zero
    end else if (fault_cnt_q == 3'h6) begin
      fault_next = 3'h6;
    end else begin
      fault_next = fault_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  tsr_i2c_slave u_slave (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .addr_sel(ADDR_SEL),
    .rd_byte(rd_byte),
    .sda_oe_q(sda_oe_c),
    .start_q(start_p),
    .stop_q(stop_p),
    .wr_stb_q(wr_stb),
    .wr_first_q(wr_first),
    .wr_byte_q(wr_byte),
    .rd_stb_q(rd_stb)
  );

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  always @* begin
    case (ptr_q[2:0])
      `TSR_PTR_TEMP: rd_byte = pick_byte(temp_q, rd_idx_q);
      `TSR_PTR_CFG: rd_byte = cfg_q;
      `TSR_PTR_HYST: rd_byte = pick_byte(hyst_q, rd_idx_q);
      `TSR_PTR_OTEMP: rd_byte = pick_byte(otemp_q, rd_idx_q);
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ptr_q <= `TSR_RST_PTR;
      cfg_q <= `TSR_RST_CFG;
      hyst_q <= `TSR_RST_HYST;
      otemp_q <= `TSR_RST_OTEMP;
      msb_hold_q <= 8'h00;
      wr_idx_q <= 1'b0;
      rd_idx_q <= 1'b0;
    end else begin
      if (start_p) begin
        wr_idx_q <= 1'b0;
        rd_idx_q <= 1'b0;
      end else if (rd_stb) begin
        rd_idx_q <= ~rd_idx_q;
      end
      if (wr_stb && wr_first) begin
        ptr_q <= wr_byte;
        wr_idx_q <= 1'b0;
      end else if (data_wr) begin
        case (ptr_q[2:0])
          `TSR_PTR_CFG: cfg_q <= wr_byte;
          `TSR_PTR_HYST, `TSR_PTR_OTEMP: begin
            wr_idx_q <= ~wr_idx_q;
            if (!wr_idx_q) begin
              msb_hold_q <= wr_byte;
            end else if (ptr_q[2:0] == `TSR_PTR_HYST) begin
              hyst_q <= {msb_hold_q, wr_byte};
            end else begin
              otemp_q <= {msb_hold_q, wr_byte};
            end
          end
          default: begin
            // temperature is read-only and the trigger stores nothing
            wr_idx_q <= wr_idx_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion scheduling
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      period_q <= 32'h0;
      busy_q <= 1'b0;
      trig_pend_q <= 1'b0;
      CONV_START <= 1'b0;
      SENSOR_PWR_EN <= 1'b0;
      temp_q <= `TSR_RST_TEMP;
    end else begin
      CONV_START <= 1'b0;
      if (trig_wr && oneshot && !shutdown) begin
        trig_pend_q <= 1'b1;
      end else if (!oneshot || shutdown) begin
        trig_pend_q <= 1'b0;
      end
      if (!normal_run) begin
        period_q <= 32'h0;
      end else if (period_q >= CONV_CYCLES - 32'h1) begin
        period_q <= 32'h0;
      end else begin
        period_q <= period_q + 32'h1;
      end
      if (!busy_q && !CONV_START) begin
        if (normal_run && period_q == 32'h0) begin
          CONV_START <= 1'b1;
          busy_q <= 1'b1;
        end else if (trig_pend_q) begin
          CONV_START <= 1'b1;
          busy_q <= 1'b1;
          trig_pend_q <= 1'b0;
        end
      end
      if (busy_q && CONV_DONE) begin
        busy_q <= 1'b0;
        temp_q <= new_temp;
      end
      SENSOR_PWR_EN <= normal_run | busy_q | CONV_START | trig_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // fault queue and alert
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      fault_cnt_q <= 3'h0;
      alert_q <= 1'b0;
      below_q <= 1'b0;
      read_seen_q <= 1'b0;
    end else begin
      if (busy_q && CONV_DONE) begin
        fault_cnt_q <= fault_next;
        below_q <= is_below;
        if (fault_next >= needed) begin
          alert_q <= 1'b1;
          // a read in the same cycle as a repeated fault still counts
          read_seen_q <= alert_q & int_mode & rd_stb;
        end else if (is_below && (!int_mode || read_seen_q || rd_stb)) begin
          alert_q <= 1'b0;
          read_seen_q <= 1'b0;
        end
      end else if (alert_q && int_mode && rd_stb) begin
        if (below_q) begin
          alert_q <= 1'b0;
        end else begin
          read_seen_q <= 1'b1;
        end
      end else if (alert_q && !int_mode && below_q) begin
        alert_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain pins
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      ALERT_OUT <= 1'b0;
      ALERT_OE <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE <= sda_oe_c;
      ALERT_OUT <= 1'b0;
      // active-low pulls when asserted; active-high pulls when idle
      if (polarity) begin
        ALERT_OE <= ~alert_q;
      end else begin
        ALERT_OE <= alert_q;
      end
    end
  end

endmodule // tsr_top

/* File: sim/tsr_chk.sv */
/*
  Port checker of the sensor register block.
  Assumes binding to tsr_top, one clock CLK_SYS, synchronous reset SYS_RST.
*/
`timescale 1ns/100ps
module tsr_chk (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire ALERT_OUT,
  input wire ALERT_OE,
  input wire CONV_START,
  input wire CONV_DONE,
  input wire SENSOR_PWR_EN
);
  // ----------------------------------------------------------------
  // converter busy tracking
  // ----------------------------------------------------------------
  reg busy_q;
  always @(posedge CLK_SYS) begin
    if (SYS_RST) busy_q <= 1'b0;
    else if (CONV_START) busy_q <= 1'b1;
    else if (CONV_DONE) busy_q <= 1'b0;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_sda_drive_low: assert property (SDA_OUT == 1'b0) else $error("sda drive value not low");
  a_alert_drive_low: assert property (ALERT_OUT == 1'b0) else $error("alert drive value not low");
  a_reset_quiet: assert property ($fell(SYS_RST) |-> !SDA_OE && !ALERT_OE && !CONV_START && !SENSOR_PWR_EN)
    else $error("outputs active during reset");
  a_boot_order: assert property ($fell(SYS_RST) |=> SENSOR_PWR_EN && CONV_START)
    else $error("no conversion after reset");
  a_start_pulse: assert property (CONV_START |=> !CONV_START) else $error("start longer than a cycle");
  a_start_busy: assert property (CONV_START |-> !busy_q) else $error("start while converting");
  a_pwr_hold: assert property (CONV_START |=> SENSOR_PWR_EN) else $error("power off during conversion");
  a_no_start_off: assert property (!SENSOR_PWR_EN && !$past(SENSOR_PWR_EN) |-> !CONV_START)
    else $error("start while powered down");
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2))
    else $error("data drive changed with clock high");
endmodule // tsr_chk

/* File: sim/tsr_mst.sv */
/*
  Two-wire bus master model, 64 ns bit period, data changed 8 ns after the clock falls.
  Assumes the bench resolves the pulled-up data wire from all drivers.
*/
`timescale 1ns/100ps
module tsr_mst (
  output reg scl,
  output reg sda_o,
  input wire sda
);
  // ----------------------------------------------------------------
  // bit and byte tasks
  // ----------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task start;
    begin
      #8 sda_o = 1'b1;
      #24 scl = 1'b1;
      #24 sda_o = 1'b0;
      #24 scl = 1'b0;
    end
  endtask
  task bitx(input b, output r);
    begin
      #8 sda_o = b;
      #24 scl = 1'b1;
      #16 r = sda;
      #16 scl = 1'b0;
    end
  endtask
  // ninth bit: mack 1 releases for the slave ack or sends a nack
  task xfer(input [7:0] w, input mack, output [7:0] rd, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitx(w[i], rd[i]);
      end
      bitx(mack, s);
      ack = ~s;
    end
  endtask
  task stop;
    begin
      #8 sda_o = 1'b0;
      #24 scl = 1'b1;
      #32 sda_o = 1'b1;
      #32;
    end
  endtask
endmodule // tsr_mst

/* File: sim/testbench.sv */
/*
  Self-checking bench: bus master model, converter stand-in, checker bind.
  Assumes tsr_top with a shortened conversion period.
*/
`timescale 1ns/100ps
module testbench;
  localparam int CC = 300;
  reg clk, rst = 1'b1, done = 1'b0;
  reg [11:0] code = 12'h000, nxt = 12'h000;
  reg [2:0] asel = 3'h0;
  wire m_scl, m_sda, sda_out, sda_oe, alert_out, alert_oe, start, pwr;
  wire sda_w = m_sda & (sda_oe ? sda_out : 1'b1);
  integer error_cnt = 0, num_checks = 0, seed = 98415, lat = 600, dcnt = 0, scnt = 0, cyc = 0, last = 0, per = 0;
  tsr_top #(.CONV_CYCLES(CC)) u_dut (.CLK_SYS(clk), .SYS_RST(rst), .SCL_IN(m_scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(asel), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe),
    .CONV_START(start), .CONV_DONE(done), .CONV_CODE(code), .SENSOR_PWR_EN(pwr));
  tsr_mst u_mst (.scl(m_scl), .sda_o(m_sda), .sda(sda_w));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // converter stand-in
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      scnt <= scnt + 1;
      per <= cyc - last;
      last <= cyc;
    end
  end
  initial forever begin
    @(negedge clk);
    if (start === 1'b1) begin
      repeat (lat) @(negedge clk);
      code = nxt;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      code = ~nxt;
      dcnt = dcnt + 1;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk_val(input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t: value %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_pin(input e, input g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t: pin %b expected %b", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] p, input [15:0] v, input integer n);
    reg [7:0] r;
    reg a;
    begin
      u_mst.start();
      u_mst.xfer({4'h9, asel, 1'b0}, 1'b1, r, a);
      u_mst.xfer(p, 1'b1, r, a);
      if (n == 2) u_mst.xfer(v[15:8], 1'b1, r, a);
      if (n > 0) u_mst.xfer(v[7:0], 1'b1, r, a);
      u_mst.stop();
    end
  endtask
  // pointer 8'hff keeps the current pointer
  task rd(input [7:0] p, input integer n, output [15:0] v);
    reg [7:0] r;
    reg a;
    integer i;
    begin
      if (p != 8'hff) wr(p, 16'h0, 0);
      u_mst.start();
      u_mst.xfer({4'h9, asel, 1'b1}, 1'b1, r, a);
      v = 16'h0;
      for (i = 0; i < n; i = i + 1) begin
        u_mst.xfer(8'hff, i == n - 1, r, a);
        v = {v[7:0], r};
      end
      u_mst.stop();
    end
  endtask
  task conv(input [11:0] c);
    integer n;
    begin
      nxt = c;
      n = dcnt;
      wait (dcnt == n + 1);
      repeat (4) @(negedge clk);
    end
  endtask
  function integer need(input [1:0] f);
    need = (f == 2'd0) ? 1 : (f == 2'd1) ? 2 : (f == 2'd2) ? 4 : 6;
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  initial begin
    // about three times the expected run, well under the cycle budget
    #400000;
    error_cnt = error_cnt + 1;
    $display("ERROR %0t: timeout", $time);
    tally_and_finish;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    reg [15:0] v, h;
    reg [11:0] c;
    integer k, j;
    @(negedge clk);
    asel = $random(seed);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(8'hff, 2, v);
    chk_val(16'h0000, v);
    rd(8'h01, 1, v);
    chk_val(16'h0000, v);
    rd(8'h02, 2, v);
    chk_val(16'h4b00, v);
    rd(8'h03, 2, v);
    chk_val(16'h5000, v);
    $display("test reset values done");
    lat = 20;
    c = $random(seed);
    conv(c);
    for (k = 2; k < 4; k = k + 1) begin
      h = $random(seed);
      wr(k[7:0], h, 2);
      rd(k[7:0], 2, v);
      chk_val(h, v);
    end
    wr(8'h01, {10'h0, h[5:0]}, 1);
    rd(8'h01, 1, v);
    chk_val({10'h0, h[5:0]}, v);
    wr(8'h01, 16'h0, 1);
    wr(8'h00, ~h, 2);
    rd(8'h00, 2, v);
    chk_val({c, 4'h0}, v);
    wr(8'h04, h, 1);
    rd(8'h04, 1, v);
    chk_val(16'h0000, v);
    conv(c);
    chk_val(CC[15:0], per[15:0]);
    $display("test register access done");
    wr(8'h02, 16'h4b00, 2);
    wr(8'h03, 16'h5000, 2);
    for (k = 0; k < 4; k = k + 1) begin
      nxt = 12'hc90;
      wr(8'h01, {8'h0, 3'b000, k[1:0], 3'b000}, 1);
      conv(12'hc90);
      for (j = 1; j < need(k[1:0]); j = j + 1) conv(12'(12'h500 + j));
      conv(12'h4ff);
      for (j = 1; j < need(k[1:0]); j = j + 1) conv(12'h500);
      chk_pin(1'b0, alert_oe);
      conv(12'h500);
      chk_pin(1'b1, alert_oe);
      conv(12'h4ff);
      chk_pin(1'b1, alert_oe);
      conv(12'hc90);
      chk_pin(1'b0, alert_oe);
    end
    $display("test fault queue done");
    wr(8'h01, 16'h0006, 1);
    conv(12'hc90);
    chk_pin(1'b1, alert_oe);
    conv(12'h7d0);
    chk_pin(1'b0, alert_oe);
    conv(12'hc90);
    chk_pin(1'b0, alert_oe);
    rd(8'h00, 2, v);
    repeat (4) @(negedge clk);
    chk_pin(1'b1, alert_oe);
    $display("test interrupt mode done");
    wr(8'h01, 16'h0020, 1);
    repeat (8) @(negedge clk);
    chk_pin(1'b0, pwr);
    k = scnt;
    repeat (2 * CC) @(negedge clk);
    chk_val(k[15:0], scnt[15:0]);
    nxt = 12'h321;
    wr(8'h04, 16'h0, 0);
    repeat (100) @(negedge clk);
    chk_val(k[15:0] + 16'h1, scnt[15:0]);
    chk_pin(1'b0, pwr);
    rd(8'h00, 2, v);
    chk_val(16'h3210, v);
    wr(8'h01, 16'h0021, 1);
    k = scnt;
    wr(8'h04, 16'h0, 0);
    repeat (2 * CC) @(negedge clk);
    chk_val(k[15:0], scnt[15:0]);
    wr(8'h01, 16'h0, 1);
    repeat (8) @(negedge clk);
    chk_pin(1'b1, pwr);
    $display("test power modes done");
    tally_and_finish;
  end
endmodule // testbench
bind tsr_top tsr_chk u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE), .CONV_START(CONV_START),
  .CONV_DONE(CONV_DONE), .SENSOR_PWR_EN(SENSOR_PWR_EN));
